// *** hw/sdc_params.svh ***
// constants for the step-data parameter bank
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// ==========================================================
// register byte offsets
`define SDC_OFS_CTRL 12'h000
`define SDC_OFS_SEL 12'h004
`define SDC_OFS_TARGET 12'h008
`define SDC_OFS_TIME 12'h00C
`define SDC_OFS_SPEED 12'h010
`define SDC_OFS_PUSH 12'h014
`define SDC_OFS_THRUST 12'h018
`define SDC_OFS_RUN 12'h01C
`define SDC_OFS_STATUS 12'h020
`define SDC_OFS_RESULT 12'h024

// ==========================================================
// field positions
`define SDC_CTRL_PULSE 0
`define SDC_CTRL_CYCLE 1
`define SDC_CTRL_VAR_LO 2
`define SDC_RUN_DIRECT 5
`define SDC_ST_ERR 0
`define SDC_ST_HOME_BAD 1
`define SDC_ST_PUSH 2
`define SDC_ST_TIME 3
`define SDC_ST_REFUSED 4

// ==========================================================
// step data figures
`define SDC_ENTRIES 20
`define SDC_DIRECT_STEP 5'h14
`define SDC_DIRECT_IDX 5'h13
`define SDC_PULSE_MAX_STEP 5'h03
`define SDC_PUSH_BASE 16'h8000
`define SDC_PUSH_MAX_MMS 16'h0014
`define SDC_SPEED_MAX 16'h0190
`define SDC_TIME_MAX 16'h1770
`define SDC_STROKE_10 32'h0000_2710
`define SDC_STROKE_20 32'h0000_4E20
`define SDC_STROKE_30 32'h0000_7530
`define SDC_STROKE_50 32'h0000_C350
`define SDC_THRUST_10 16'h0032
`define SDC_THRUST_20 16'h0030
`define SDC_THRUST_30 16'h0027
`define SDC_THRUST_50 16'h0014

`endif

// *** hw/sdc_pkg.sv ***
// types shared by the step-data parameter bank
package sdc_pkg;
    typedef enum logic [1:0] {
        SDC_VAR_10,
        SDC_VAR_20,
        SDC_VAR_30,
        SDC_VAR_50
    } sdc_variant_t;

    typedef enum logic [1:0] {
        SDC_IDLE,
        SDC_ACCESS,
        SDC_RUN
    } sdc_phase_t;
endpackage

// *** hw/sdc_step_check.sv ***
// executability check of one step entry
`timescale 1ns/1ns
`include "sdc_params.svh"

module sdc_step_check (
    input wire logic [31:0] target,
    input wire logic [15:0] pos_time,
    input wire logic [15:0] speed,
    input wire logic [15:0] push,
    input wire logic [15:0] thrust,
    input wire sdc_pkg::sdc_variant_t variant,
    input wire logic is_homing,
    input wire logic pulse_mode,
    input wire logic cycle_method,
    output logic err,
    output logic home_bad,
    output logic push_en,
    output logic time_used,
    output logic [15:0] push_mms
);
    logic [31:0] stroke;
    logic [15:0] thr_max;
    logic push_bad;

    always_comb begin
        case (variant)
            sdc_pkg::SDC_VAR_10: begin
                stroke = `SDC_STROKE_10;
                thr_max = `SDC_THRUST_10;
            end
            sdc_pkg::SDC_VAR_20: begin
                stroke = `SDC_STROKE_20;
                thr_max = `SDC_THRUST_20;
            end
            sdc_pkg::SDC_VAR_30: begin
                stroke = `SDC_STROKE_30;
                thr_max = `SDC_THRUST_30;
            end
            default: begin
                stroke = `SDC_STROKE_50;
                thr_max = `SDC_THRUST_50;
            end
        endcase
        // offset code: above base means pushing at the excess
        push_en = push > `SDC_PUSH_BASE; // [R3] [R11]
        push_mms = push_en ? push - `SDC_PUSH_BASE : 16'h0000; // [R3]
        push_bad = push_en ? (push_mms > `SDC_PUSH_MAX_MMS)
                           : (push > `SDC_PUSH_MAX_MMS && push != `SDC_PUSH_BASE);
        // homing speed is the raw value or the excess over base; either zero is fatal
        home_bad = is_homing && (push == 16'h0000 || push == `SDC_PUSH_BASE); // [R2]
        time_used = cycle_method && !pulse_mode; // [R10]
        err = target[31] || target > stroke // [R6]
            || speed > `SDC_SPEED_MAX // [R6]
            || thrust > thr_max // [R4]
            || (time_used && pos_time > `SDC_TIME_MAX)
            || push_bad || home_bad; // [R6]
    end
endmodule // sdc_step_check

// *** hw/sdc_bank.sv ***
// step-data parameter bank with APB access and run-time check
// ==========================================================
// Function
// [R1] The host must not store pushing speed 0 or 32768 in the homing entry.
// [R2] A homing entry whose speed decodes to zero blocks return to origin.
// [R3] From the second entry on, 32768 means plain positioning and 32768+N pushing at N mm/s.
// [R4] The thrust upper limit follows the fitted stroke variant, 5.0 down to 2.0.
// [R5] Step 20 holds direct-operation parameters and is not an ordinary selectable step.
// [R6] Running a step with target off-stroke, speed over 400 mm/s or other bad value flags an error.
// [R7] Pulse-input mode numbers steps one lower and allows steps up to 3 only.
// [R8] Each access selects one entry by step number and touches that entry only.
// [R9] The target field is the destination when positioning and the push start when pushing.
// [R10] Positioning time is honoured only in step-data input with the cycle-time method.
// [R11] A pushing-speed value of 32768 or less skips the pushing phase whatever the thrust.
// [R12] The step-data error is sticky, readable, and cleared by reset or an acknowledge write.
`timescale 1ns/1ns
`include "sdc_params.svh"

module sdc_bank #(
    parameter int ENTRIES = `SDC_ENTRIES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic step_err,
    output logic push_phase,
    output logic target_is_push_start
);
    typedef struct packed {
        logic [ENTRIES-1:0][31:0] target;
        logic [ENTRIES-1:0][15:0] pos_time;
        logic [ENTRIES-1:0][15:0] speed;
        logic [ENTRIES-1:0][15:0] push;
        logic [ENTRIES-1:0][15:0] thrust;
        logic pulse_mode;
        logic cycle_method;
        sdc_pkg::sdc_variant_t variant;
        logic [4:0] sel;
        logic [4:0] run_idx;
        sdc_pkg::sdc_phase_t phase;
        logic err;
        logic home_bad;
        logic push_en;
        logic time_used;
        logic refused;
        logic [15:0] push_mms;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sdc_state_t;

    sdc_state_t st_r;
    sdc_state_t st_nxt;

    // ==========================================================
    // step number to entry index; bit 5 set means not reachable
    function automatic logic [5:0] step_index(input logic [4:0] step, input logic pulse,
                                              input logic direct);
        logic [5:0] idx;
        idx = 6'h20;
        if (direct) begin
            idx = {1'b0, `SDC_DIRECT_IDX}; // [R5]
        end else if (pulse) begin
            if (step <= `SDC_PULSE_MAX_STEP) begin
                idx = {1'b0, step}; // [R7]
            end
        end else if (step != 5'h00 && step < `SDC_DIRECT_STEP) begin
            idx = {1'b0, step - 5'h01}; // [R5]
        end
        return idx;
    endfunction

    // ==========================================================
    // checker of the entry last run
    logic chk_err;
    logic chk_home_bad;
    logic chk_push_en;
    logic chk_time_used;
    logic [15:0] chk_push_mms;

    sdc_step_check u_check (
        .target(st_r.target[st_r.run_idx]),
        .pos_time(st_r.pos_time[st_r.run_idx]),
        .speed(st_r.speed[st_r.run_idx]),
        .push(st_r.push[st_r.run_idx]),
        .thrust(st_r.thrust[st_r.run_idx]),
        .variant(st_r.variant),
        .is_homing(st_r.run_idx == 5'h00),
        .pulse_mode(st_r.pulse_mode),
        .cycle_method(st_r.cycle_method),
        .err(chk_err),
        .home_bad(chk_home_bad),
        .push_en(chk_push_en),
        .time_used(chk_time_used),
        .push_mms(chk_push_mms)
    );

    // ==========================================================
    // next state
    logic [5:0] sel_idx;
    logic [5:0] run_sel;
    logic [4:0] si;
    logic wr_done;
    logic ack;
    logic run_set;

    always_comb begin
        st_nxt = st_r;
        sel_idx = step_index(st_r.sel, st_r.pulse_mode, 1'b0); // [R8]
        si = sel_idx[4:0];
        run_sel = step_index(pwdata[4:0], st_r.pulse_mode, pwdata[`SDC_RUN_DIRECT]);
        wr_done = psel && penable && st_r.pready && pwrite;
        ack = 1'b0;
        run_set = 1'b0;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;

        // one wait state: answer prepared in the first access cycle
        if (psel && penable && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h0000_0000;
            case (paddr)
                `SDC_OFS_CTRL: begin
                    st_nxt.prdata[`SDC_CTRL_PULSE] = st_r.pulse_mode;
                    st_nxt.prdata[`SDC_CTRL_CYCLE] = st_r.cycle_method;
                    st_nxt.prdata[`SDC_CTRL_VAR_LO +: 2] = st_r.variant;
                end
                `SDC_OFS_SEL: st_nxt.prdata[4:0] = st_r.sel;
                `SDC_OFS_TARGET, `SDC_OFS_TIME, `SDC_OFS_SPEED, `SDC_OFS_PUSH,
                `SDC_OFS_THRUST: begin
                    // entry fields go only to the selected entry
                    if (sel_idx[5]) begin
                        st_nxt.pslverr = 1'b1; // [R8]
                    end else if (paddr == `SDC_OFS_TARGET) begin
                        st_nxt.prdata = st_r.target[si];
                    end else if (paddr == `SDC_OFS_TIME) begin
                        st_nxt.prdata[15:0] = st_r.pos_time[si];
                    end else if (paddr == `SDC_OFS_SPEED) begin
                        st_nxt.prdata[15:0] = st_r.speed[si];
                    end else if (paddr == `SDC_OFS_PUSH) begin
                        st_nxt.prdata[15:0] = st_r.push[si];
                    end else begin
                        st_nxt.prdata[15:0] = st_r.thrust[si];
                    end
                end
                `SDC_OFS_RUN: begin
                    st_nxt.prdata[4:0] = st_r.run_idx;
                    st_nxt.pslverr = pwrite && run_sel[5]; // [R5] [R7]
                end
                `SDC_OFS_STATUS: begin
                    st_nxt.prdata[`SDC_ST_ERR] = st_r.err; // [R12]
                    st_nxt.prdata[`SDC_ST_HOME_BAD] = st_r.home_bad;
                    st_nxt.prdata[`SDC_ST_PUSH] = st_r.push_en;
                    st_nxt.prdata[`SDC_ST_TIME] = st_r.time_used;
                    st_nxt.prdata[`SDC_ST_REFUSED] = st_r.refused;
                end
                `SDC_OFS_RESULT: st_nxt.prdata[15:0] = st_r.push_mms;
                default: st_nxt.pslverr = 1'b1;
            endcase
        end

        // writes land at the edge where pready is sampled high
        if (wr_done && !st_r.pslverr) begin
            case (paddr)
                `SDC_OFS_CTRL: begin
                    st_nxt.pulse_mode = pwdata[`SDC_CTRL_PULSE];
                    st_nxt.cycle_method = pwdata[`SDC_CTRL_CYCLE];
                    st_nxt.variant = sdc_pkg::sdc_variant_t'(pwdata[`SDC_CTRL_VAR_LO +: 2]);
                end
                `SDC_OFS_SEL: st_nxt.sel = pwdata[4:0];
                `SDC_OFS_TARGET: st_nxt.target[si] = pwdata; // [R8]
                `SDC_OFS_TIME: st_nxt.pos_time[si] = pwdata[15:0]; // [R8]
                `SDC_OFS_SPEED: st_nxt.speed[si] = pwdata[15:0]; // [R8]
                `SDC_OFS_PUSH: st_nxt.push[si] = pwdata[15:0]; // [R8]
                `SDC_OFS_THRUST: st_nxt.thrust[si] = pwdata[15:0]; // [R8]
                `SDC_OFS_RUN: begin
                    st_nxt.run_idx = run_sel[4:0];
                    st_nxt.phase = sdc_pkg::SDC_RUN;
                end
                `SDC_OFS_STATUS: ack = pwdata[`SDC_ST_ERR]; // [R12]
                default: ack = 1'b0;
            endcase
        end
        if (wr_done && st_r.pslverr && paddr == `SDC_OFS_RUN) begin
            st_nxt.refused = 1'b1; // [R5] [R7]
        end

        // run check one cycle after the run write, once the index has settled
        case (st_r.phase)
            sdc_pkg::SDC_RUN: begin
                run_set = chk_err; // [R6]
                st_nxt.home_bad = chk_home_bad; // [R2]
                st_nxt.push_en = chk_push_en; // [R9] [R11]
                st_nxt.time_used = chk_time_used; // [R10]
                st_nxt.push_mms = chk_push_mms; // [R3]
                st_nxt.refused = 1'b0;
                st_nxt.phase = sdc_pkg::SDC_IDLE;
            end
            default: st_nxt.phase = st_nxt.phase;
        endcase

        // set beats acknowledge in the same cycle
        st_nxt.err = (st_r.err && !ack) || run_set; // [R12]
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign step_err = st_r.err;
    assign push_phase = st_r.push_en;
    // pushing step: the target is where pushing begins
    assign target_is_push_start = st_r.push_en; // [R9]
endmodule // sdc_bank

// *** dv/sdc_bank_monitor.sv ***
// port-level property checks for the step-data bank
`timescale 1ns/1ns
module sdc_bank_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic step_err,
    input wire logic push_phase,
    input wire logic target_is_push_start
);
    logic [2:0] since_run_r;
    logic acc;
    logic ack;
    assign acc = psel && penable && pready;
    assign ack = acc && pwrite && paddr == 12'h020 && pwdata[0];
    // run results may only move within a few cycles of a run write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_run_r <= 3'h7;
        else if (acc && pwrite && paddr == 12'h01C) since_run_r <= 3'h0;
        else if (since_run_r != 3'h7) since_run_r <= since_run_r + 3'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held over two cycles");
    a_ready_bus: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    a_slverr_with: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_refused: assert property (acc && paddr > 12'h024 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_err_sticky: assert property (step_err && !ack |=> step_err)
        else $error("step error dropped without acknowledge");
    a_err_cause: assert property ($rose(step_err) |-> since_run_r <= 3'h3)
        else $error("step error raised without a run");
    a_push_cause: assert property ($changed(push_phase) |-> since_run_r <= 3'h3)
        else $error("push flag moved without a run");
    a_push_start: assert property (acc && !pwrite && paddr == 12'h020 |->
        prdata[2] == target_is_push_start)
        else $error("target meaning differs from push flag");
endmodule // sdc_bank_monitor

// *** dv/sdc_host.sv ***
// bus-master model of the host that owns the step data
`timescale 1ns/1ns
module sdc_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    bit tmo = 1'b0;
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        tmo = pready !== 1'h1;
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule // sdc_host

// *** dv/sdc_bank_tb.sv ***
// self-checking bench for the step-data bank
`timescale 1ns/1ns
module sdc_bank_tb;
    typedef struct {bit w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} sdc_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, step_err, push_phase, push_start, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int mismatches = 0;
    int compares = 0;
    sdc_row_t rows[16] = '{
        '{1'h0, 12'h000, 32'h0, 32'h0, 1'h0}, '{1'h1, 12'h004, 32'h1, 32'h0, 1'h0},
        '{1'h1, 12'h014, 32'h8006, 32'h0, 1'h0}, '{1'h1, 12'h008, 32'h1388, 32'h0, 1'h0},
        '{1'h1, 12'h010, 32'h64, 32'h0, 1'h0}, '{1'h1, 12'h018, 32'h32, 32'h0, 1'h0},
        '{1'h1, 12'h004, 32'h2, 32'h0, 1'h0}, '{1'h1, 12'h014, 32'h8000, 32'h0, 1'h0},
        '{1'h0, 12'h014, 32'h0, 32'h8000, 1'h0}, '{1'h1, 12'h004, 32'h1, 32'h0, 1'h0},
        '{1'h0, 12'h014, 32'h0, 32'h8006, 1'h0}, '{1'h0, 12'h040, 32'h0, 32'h0, 1'h1},
        '{1'h1, 12'h004, 32'h14, 32'h0, 1'h0}, '{1'h1, 12'h008, 32'h0, 32'h0, 1'h1},
        '{1'h1, 12'h004, 32'h3, 32'h0, 1'h0}, '{1'h1, 12'h018, 32'h30, 32'h0, 1'h0}};
    always #4 pclk = ~pclk;
    sdc_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .step_err(step_err), .push_phase(push_phase),
        .target_is_push_start(push_start));
    sdc_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task op(input bit w, input logic [11:0] a, input logic [31:0] d);
        host.xfer(w, a, d, q, e);
        if (host.tmo) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    // status is read after the run so the check has landed
    task run(input logic [31:0] s, input logic [31:0] m, input logic [31:0] x);
        op(1'h1, 12'h01C, s);
        op(1'h0, 12'h020, 32'h0);
        chk("status", q & m, x);
        chk("step_err", {31'h0, step_err}, {31'h0, x[0]});
        $display("run %h done", s);
    endtask
    // ==========================================================
    // sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        foreach (rows[i]) begin
            op(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("rdata", q, rows[i].q);
            chk("slverr", {31'h0, e}, {31'h0, rows[i].e});
        end
        $display("table done");
        run(32'h1, 32'h7, 32'h4);
        chk("push_phase", {31'h0, push_phase}, 32'h1);
        chk("push start", {31'h0, push_start}, 32'h1);
        op(1'h0, 12'h024, 32'h0);
        chk("push speed", q & 32'hFFFF, 32'h6);
        // thrust given on a plain positioning entry must not start pushing
        op(1'h1, 12'h004, 32'h2);
        op(1'h1, 12'h018, 32'hA);
        run(32'h2, 32'h5, 32'h0);
        chk("push_phase", {31'h0, push_phase}, 32'h0);
        chk("push start", {31'h0, push_start}, 32'h0);
        op(1'h1, 12'h004, 32'h3);
        for (int v = 0; v < 4; v++) begin
            op(1'h1, 12'h000, 32'(v) << 2);
            run(32'h3, 32'h1, v > 1 ? 32'h1 : 32'h0);
            op(1'h1, 12'h020, 32'h1);
        end
        op(1'h1, 12'h000, 32'h0);
        op(1'h1, 12'h010, 32'h191);
        run(32'h3, 32'h1, 32'h1);
        run(32'h1, 32'h1, 32'h1);
        op(1'h1, 12'h020, 32'h1);
        run(32'h1, 32'h1, 32'h0);
        op(1'h1, 12'h000, 32'h2);
        run(32'h1, 32'hC, 32'hC);
        op(1'h1, 12'h004, 32'h1);
        op(1'h1, 12'h00C, 32'h1771);
        run(32'h1, 32'h9, 32'h9);
        op(1'h1, 12'h020, 32'h1);
        op(1'h1, 12'h000, 32'h0);
        op(1'h1, 12'h014, 32'h8000);
        run(32'h1, 32'h3, 32'h3);
        op(1'h1, 12'h01C, 32'h20);
        op(1'h0, 12'h01C, 32'h0);
        chk("run index", q & 32'h1F, 32'h13);
        op(1'h1, 12'h000, 32'h1);
        op(1'h1, 12'h004, 32'h4);
        op(1'h1, 12'h008, 32'h0);
        chk("pulse step 4", {31'h0, e}, 32'h1);
        op(1'h1, 12'h004, 32'h3);
        op(1'h1, 12'h008, 32'h0);
        chk("pulse step 3", {31'h0, e}, 32'h0);
        op(1'h1, 12'h01C, 32'h4);
        chk("pulse run 4", {31'h0, e}, 32'h1);
        op(1'h0, 12'h020, 32'h0);
        chk("run refused", q & 32'h10, 32'h10);
        $display("modes done");
        presetn <= 1'h0;
        @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        op(1'h0, 12'h000, 32'h0);
        chk("ctrl after reset", q, 32'h0);
        chk("step_err after reset", {31'h0, step_err}, 32'h0);
        $display("reset done");
        report_and_stop();
    end
endmodule // sdc_bank_tb
bind sdc_bank sdc_bank_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_err(step_err), .push_phase(push_phase),
    .target_is_push_start(target_is_push_start));
